/* hw/plm_pkg.sv */
package plm_pkg;
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned DC_TIME_MS  = 1000;
    localparam int unsigned DC_CYC      = CLK_HZ / 1000 * DC_TIME_MS;
    localparam int unsigned SEC_CYC     = CLK_HZ;
    localparam int unsigned HOUR_SEC    = 3600;
    localparam logic [6:0]  HUNDRED_H   = 7'h64;

    localparam logic [7:0] ADR_LIFE_STAT = 8'h00;
    localparam logic [7:0] ADR_INRUSH    = 8'h04;
    localparam logic [7:0] ADR_CTRL_CAP  = 8'h08;
    localparam logic [7:0] ADR_MAIN_CAP  = 8'h0C;
    localparam logic [7:0] ADR_MEAS_CTL  = 8'h10;
    localparam logic [7:0] ADR_HOURS     = 8'h14;
    localparam logic [7:0] ADR_LIMIT     = 8'h18;
    localparam logic [7:0] ADR_TERM_SEL  = 8'h1C;

    localparam logic [6:0]  LIFE_FULL     = 7'h64;
    localparam logic [6:0]  LIFE_TEN      = 7'h0A;
    localparam logic [6:0]  MAIN_LIMIT    = 7'h55;
    localparam logic [13:0] CLOSE_PER_PCT = 14'h2710;
    localparam logic [15:0] HOURS_MAX     = 16'h270E;
    localparam logic [15:0] LIMIT_OFF     = 16'h270F;
    localparam logic [15:0] LIMIT_RST     = 16'h270F;
    localparam logic [7:0]  TERM_POS      = 8'h5F;
    localparam logic [7:0]  TERM_NEG      = 8'hC3;

    localparam int unsigned BIT_CTRL_CAP = 0;
    localparam int unsigned BIT_MAIN_CAP = 1;
    localparam int unsigned BIT_FAN      = 2;
    localparam int unsigned BIT_INRUSH   = 3;

    typedef enum logic [3:0] {
        MS_IDLE   = 4'h0,
        MS_ARMED  = 4'h1,
        MS_RUN    = 4'h2,
        MS_DONE   = 4'h3,
        MS_FORCED = 4'h8,
        MS_ERROR  = 4'h9
    } plm_meas_t;
endpackage

/* hw/plm_monitor.sv */
module plm_monitor #(
    parameter int unsigned NFAN     = 2,
    parameter int unsigned DC_CYC   = plm_pkg::DC_CYC,
    parameter int unsigned SEC_CYC  = plm_pkg::SEC_CYC,
    parameter int unsigned HOUR_SEC = plm_pkg::HOUR_SEC,
    parameter int unsigned WEAR_PCT = 1000
) (
    input  wire logic            i_clk,
    input  wire logic            i_rst_b,
    input  wire logic [7:0]      i_awaddr,
    input  wire logic            i_awvalid,
    output logic                 o_awready,
    input  wire logic [31:0]     i_wdata,
    input  wire logic [3:0]      i_wstrb,
    input  wire logic            i_wvalid,
    output logic                 o_wready,
    output logic [1:0]           o_bresp,
    output logic                 o_bvalid,
    input  wire logic            i_bready,
    input  wire logic [7:0]      i_araddr,
    input  wire logic            i_arvalid,
    output logic                 o_arready,
    output logic [31:0]          o_rdata,
    output logic [1:0]           o_rresp,
    output logic                 o_rvalid,
    input  wire logic            i_rready,
    input  wire logic            i_contact_close,
    input  wire logic            i_running,
    input  wire logic            i_wear_tick,
    input  wire logic            i_power_off,
    input  wire logic            i_start_cmd,
    input  wire logic            i_output_shutoff_input,
    input  wire logic            i_trip,
    input  wire logic            i_motor_present,
    input  wire logic [6:0]      i_cap_meas_pct,
    input  wire logic [NFAN-1:0] i_fan_slow,
    input  wire logic [3:0]      i_part_replaced,
    output logic                 o_life_alarm_out,
    output logic                 o_maint_alarm_out,
    output logic                 o_fan_fault_indication,
    output logic                 o_maintenance_indication,
    output logic                 o_term_out,
    output logic                 o_dc_inject,
    output logic                 o_nv_store
);
    logic [13:0] close_cnt_q;
    logic [6:0]  inrush_q;
    logic [31:0] wear_cnt_q;
    logic [6:0]  ctrl_cap_q;
    logic [6:0]  main_cap_q;
    logic        main_meas_q;
    logic        fan_bit_q;
    logic [3:0]  status_q;
    plm_pkg::plm_meas_t meas_q;
    logic [31:0] dc_cnt_q;
    logic        pwr_off_q;
    logic [31:0] sec_cnt_q;
    logic [11:0] sec_q;
    logic [6:0]  hour_q;
    logic [15:0] hours_q;
    logic [15:0] limit_q;
    logic [7:0]  term_sel_q;
    logic        wr_go;
    logic [15:0] wd;
    logic        maint_hit;

    assign wr_go = o_awready && o_wready;
    assign wd    = i_wdata[15:0];

    function automatic logic wr_to(input logic [7:0] a);
        wr_to = wr_go && (i_awaddr == a) && (i_wstrb[1:0] == 2'b11);
    endfunction

    // Inrush limiter wear from contact closings
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            close_cnt_q <= 14'h0000;
            inrush_q    <= plm_pkg::LIFE_FULL;
        end else if (i_part_replaced[plm_pkg::BIT_INRUSH]) begin
            close_cnt_q <= 14'h0000;
            inrush_q    <= plm_pkg::LIFE_FULL;
        end else if (i_contact_close) begin
            if (close_cnt_q == plm_pkg::CLOSE_PER_PCT - 14'h0001) begin
                close_cnt_q <= 14'h0000;
                if (inrush_q != 7'h00) begin
                    inrush_q <= inrush_q - 7'h01;
                end
            end else begin
                close_cnt_q <= close_cnt_q + 14'h0001;
            end
        end
    end

    // Temperature weighted wear ticks come from the thermal front end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wear_cnt_q <= 32'h0000_0000;
            ctrl_cap_q <= plm_pkg::LIFE_FULL;
        end else if (i_part_replaced[plm_pkg::BIT_CTRL_CAP]) begin
            wear_cnt_q <= 32'h0000_0000;
            ctrl_cap_q <= plm_pkg::LIFE_FULL;
        end else if (i_running && i_wear_tick) begin
            if (wear_cnt_q == 32'(WEAR_PCT - 1)) begin
                wear_cnt_q <= 32'h0000_0000;
                if (ctrl_cap_q != 7'h00) begin
                    ctrl_cap_q <= ctrl_cap_q - 7'h01;
                end
            end else begin
                wear_cnt_q <= wear_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Capacitance measurement sequencer; code doubles as state
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meas_q      <= plm_pkg::MS_IDLE;
            dc_cnt_q    <= 32'h0000_0000;
            o_dc_inject <= 1'b0;
            main_cap_q  <= plm_pkg::LIFE_FULL;
            main_meas_q <= 1'b0;
            pwr_off_q   <= 1'b0;
        end else begin
            pwr_off_q <= i_power_off;
            if (i_part_replaced[plm_pkg::BIT_MAIN_CAP]) begin
                main_cap_q  <= plm_pkg::LIFE_FULL;
                main_meas_q <= 1'b0;
            end
            case (meas_q)
                plm_pkg::MS_RUN: begin
                    dc_cnt_q <= dc_cnt_q + 32'h0000_0001;
                    if (i_trip || !i_motor_present) begin
                        meas_q      <= plm_pkg::MS_ERROR;
                        o_dc_inject <= 1'b0;
                    end else if (i_start_cmd || i_output_shutoff_input) begin
                        meas_q      <= plm_pkg::MS_FORCED;
                        o_dc_inject <= 1'b0;
                    end else if (!i_power_off) begin
                        // Power back early: measurement stays armed
                        meas_q      <= plm_pkg::MS_ARMED;
                        o_dc_inject <= 1'b0;
                    end else if (dc_cnt_q == 32'(DC_CYC - 1)) begin
                        meas_q      <= plm_pkg::MS_DONE;
                        o_dc_inject <= 1'b0;
                        main_cap_q  <= i_cap_meas_pct;
                        main_meas_q <= 1'b1;
                    end
                end
                plm_pkg::MS_ARMED: begin
                    if (i_power_off && !pwr_off_q) begin
                        if (i_trip || !i_motor_present) begin
                            meas_q <= plm_pkg::MS_ERROR;
                        end else begin
                            meas_q      <= plm_pkg::MS_RUN;
                            dc_cnt_q    <= 32'h0000_0000;
                            o_dc_inject <= 1'b1;
                        end
                    end else if (wr_to(plm_pkg::ADR_MEAS_CTL)
                                 && wd == 16'h0000) begin
                        meas_q <= plm_pkg::MS_IDLE;
                    end
                end
                default: begin
                    // Only 0 and 1 are writable codes
                    if (wr_to(plm_pkg::ADR_MEAS_CTL)) begin
                        if (wd == 16'h0001) begin
                            meas_q <= plm_pkg::MS_ARMED;
                        end else if (wd == 16'h0000) begin
                            meas_q <= plm_pkg::MS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Fan slowdown latch; set wins over replacement clear
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fan_bit_q <= 1'b0;
        end else if (|i_fan_slow) begin
            fan_bit_q <= 1'b1;
        end else if (i_part_replaced[plm_pkg::BIT_FAN]) begin
            fan_bit_q <= 1'b0;
        end
    end

    // Status follows life figures, so it only clears on restoration
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            status_q               <= 4'h0;
            o_life_alarm_out       <= 1'b0;
            o_fan_fault_indication <= 1'b0;
        end else begin
            status_q[plm_pkg::BIT_CTRL_CAP] <=
                ctrl_cap_q < plm_pkg::LIFE_TEN;
            status_q[plm_pkg::BIT_MAIN_CAP] <= main_meas_q &&
                main_cap_q <= plm_pkg::MAIN_LIMIT;
            status_q[plm_pkg::BIT_FAN]      <= fan_bit_q;
            status_q[plm_pkg::BIT_INRUSH]   <=
                inrush_q <= plm_pkg::LIFE_TEN;
            o_life_alarm_out       <= |status_q;
            o_fan_fault_indication <= fan_bit_q;
        end
    end

    // Whole hours only; a partial hour is lost at switch-off
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sec_cnt_q  <= 32'h0000_0000;
            sec_q      <= 12'h000;
            hour_q     <= 7'h00;
            hours_q    <= 16'h0000;
            o_nv_store <= 1'b0;
        end else begin
            o_nv_store <= 1'b0;
            if (wr_to(plm_pkg::ADR_HOURS) && wd == 16'h0000) begin
                sec_cnt_q <= 32'h0000_0000;
                sec_q     <= 12'h000;
                hour_q    <= 7'h00;
                hours_q   <= 16'h0000;
            end else if (i_power_off) begin
                sec_cnt_q <= 32'h0000_0000;
                sec_q     <= 12'h000;
            end else if (sec_cnt_q == 32'(SEC_CYC - 1)) begin
                sec_cnt_q <= 32'h0000_0000;
                if (sec_q == 12'(HOUR_SEC - 1)) begin
                    sec_q      <= 12'h000;
                    o_nv_store <= 1'b1;
                    if (hour_q == plm_pkg::HUNDRED_H - 7'h01) begin
                        hour_q <= 7'h00;
                        if (hours_q != plm_pkg::HOURS_MAX) begin
                            hours_q <= hours_q + 16'h0001;
                        end
                    end else begin
                        hour_q <= hour_q + 7'h01;
                    end
                end else begin
                    sec_q <= sec_q + 12'h001;
                end
            end else begin
                sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
            end
        end
    end

    assign maint_hit = limit_q != plm_pkg::LIMIT_OFF
                       && hours_q >= limit_q;

    // Limit and terminal selector; out of range limits are dropped
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            limit_q    <= plm_pkg::LIMIT_RST;
            term_sel_q <= 8'h00;
        end else begin
            if (wr_to(plm_pkg::ADR_LIMIT) && wd <= plm_pkg::LIMIT_OFF) begin
                limit_q <= wd;
            end
            if (wr_to(plm_pkg::ADR_TERM_SEL)) begin
                term_sel_q <= i_wdata[7:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_maint_alarm_out        <= 1'b0;
            o_maintenance_indication <= 1'b0;
            o_term_out               <= 1'b0;
        end else begin
            o_maint_alarm_out        <= maint_hit;
            o_maintenance_indication <= maint_hit;
            if (term_sel_q == plm_pkg::TERM_POS) begin
                o_term_out <= maint_hit;
            end else if (term_sel_q == plm_pkg::TERM_NEG) begin
                o_term_out <= !maint_hit;
            end else begin
                o_term_out <= 1'b0;
            end
        end
    end

    // Write channel: both halves taken together, one in flight
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= 2'b00;
        end else begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            if (wr_go) begin
                o_bvalid <= 1'b1;
                if (i_awaddr > plm_pkg::ADR_TERM_SEL
                    || i_awaddr[1:0] != 2'b00) begin
                    o_bresp <= 2'b10;
                end else begin
                    o_bresp <= 2'b00;
                end
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end else if (i_awvalid && i_wvalid && !o_bvalid) begin
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= 2'b00;
        end else begin
            o_arready <= 1'b0;
            if (o_arready) begin
                o_rvalid <= 1'b1;
                o_rresp  <= 2'b00;
                o_rdata  <= 32'h0000_0000;
                if (i_araddr == plm_pkg::ADR_LIFE_STAT) begin
                    o_rdata[3:0] <= status_q;
                end else if (i_araddr == plm_pkg::ADR_INRUSH) begin
                    o_rdata[6:0] <= inrush_q;
                end else if (i_araddr == plm_pkg::ADR_CTRL_CAP) begin
                    o_rdata[6:0] <= ctrl_cap_q;
                end else if (i_araddr == plm_pkg::ADR_MAIN_CAP) begin
                    o_rdata[6:0] <= main_cap_q;
                end else if (i_araddr == plm_pkg::ADR_MEAS_CTL) begin
                    o_rdata[3:0] <= meas_q;
                end else if (i_araddr == plm_pkg::ADR_HOURS) begin
                    o_rdata[15:0] <= hours_q;
                end else if (i_araddr == plm_pkg::ADR_LIMIT) begin
                    o_rdata[15:0] <= limit_q;
                end else if (i_araddr == plm_pkg::ADR_TERM_SEL) begin
                    o_rdata[7:0] <= term_sel_q;
                end else begin
                    o_rresp <= 2'b10;
                end
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end else if (i_arvalid && !o_rvalid) begin
                o_arready <= 1'b1;
            end
        end
    end

    property p_inrush_step;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_contact_close && !i_part_replaced[3] && inrush_q != 7'h00
         && close_cnt_q == 14'h270F) |=> inrush_q == $past(inrush_q) - 7'h01;
    endproperty
    a_inrush_step: assert property (p_inrush_step)
        else $error("inrush life did not step");

    property p_inrush_bit;
        @(posedge i_clk) disable iff (!i_rst_b)
        inrush_q <= 7'h0A |=> status_q[3] ##1 o_life_alarm_out;
    endproperty
    a_inrush_bit: assert property (p_inrush_bit)
        else $error("inrush bit or alarm missing");

    property p_ctrl_bit;
        @(posedge i_clk) disable iff (!i_rst_b)
        ctrl_cap_q < 7'h0A |=> status_q[0];
    endproperty
    a_ctrl_bit: assert property (p_ctrl_bit)
        else $error("control capacitor bit missing");

    sequence s_arm_off;
        meas_q == plm_pkg::MS_ARMED && i_power_off && !pwr_off_q
        && !i_trip && i_motor_present;
    endsequence
    property p_meas_start;
        @(posedge i_clk) disable iff (!i_rst_b)
        s_arm_off |=> meas_q == plm_pkg::MS_RUN && o_dc_inject;
    endproperty
    a_meas_start: assert property (p_meas_start)
        else $error("measurement did not start");

    property p_dc_only_run;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_dc_inject |-> meas_q == plm_pkg::MS_RUN
                        && dc_cnt_q < 32'(DC_CYC);
    endproperty
    a_dc_only_run: assert property (p_dc_only_run)
        else $error("dc injection outside its window");

    property p_no_code_write;
        @(posedge i_clk) disable iff (!i_rst_b)
        (wr_to(plm_pkg::ADR_MEAS_CTL) && wd > 16'h0001
         && meas_q != plm_pkg::MS_RUN && meas_q != plm_pkg::MS_ARMED)
        |=> meas_q == $past(meas_q);
    endproperty
    a_no_code_write: assert property (p_no_code_write)
        else $error("read only code accepted");

    property p_forced;
        @(posedge i_clk) disable iff (!i_rst_b)
        (meas_q == plm_pkg::MS_RUN && i_start_cmd && !i_trip
         && i_motor_present) |=> meas_q == plm_pkg::MS_FORCED;
    endproperty
    a_forced: assert property (p_forced)
        else $error("start command did not force end");

    property p_fan;
        @(posedge i_clk) disable iff (!i_rst_b)
        |i_fan_slow |=> fan_bit_q ##1 (status_q[2] && o_fan_fault_indication);
    endproperty
    a_fan: assert property (p_fan)
        else $error("fan slowdown not flagged");

    property p_hours_sat;
        @(posedge i_clk) disable iff (!i_rst_b)
        hours_q <= plm_pkg::HOURS_MAX;
    endproperty
    a_hours_sat: assert property (p_hours_sat)
        else $error("maintenance timer passed its clamp");

    property p_maint;
        @(posedge i_clk) disable iff (!i_rst_b)
        (limit_q != 16'h270F && hours_q >= limit_q) |=>
            o_maint_alarm_out && o_maintenance_indication;
    endproperty
    a_maint: assert property (p_maint)
        else $error("maintenance alarm missing");

    property p_limit_off;
        @(posedge i_clk) disable iff (!i_rst_b)
        limit_q == 16'h270F |=> !o_maint_alarm_out;
    endproperty
    a_limit_off: assert property (p_limit_off)
        else $error("alarm active while disabled");
endmodule

/* test/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("Error %0t: got %h exp %h", $time, a, e); end end
    logic        i_clk = 1'b0, i_rst_b = 1'b0;
    logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0]  i_wstrb = 4'hf, i_part_replaced = 4'h0;
    logic        i_contact_close = 1'b0, i_running = 1'b0;
    logic        i_wear_tick = 1'b0, i_power_off = 1'b0, i_trip = 1'b0;
    logic        i_start_cmd = 1'b0, i_output_shutoff_input = 1'b0;
    logic        i_motor_present = 1'b1;
    logic [6:0]  i_cap_meas_pct = 7'h00, pct;
    logic [1:0]  i_fan_slow = 2'h0, o_bresp, o_rresp;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [31:0] o_rdata;
    logic        o_life_alarm_out, o_maint_alarm_out, o_fan_fault_indication;
    logic        o_maintenance_indication, o_term_out, o_dc_inject, o_nv_store;
    int          fails = 0, n_tests = 0, n_nv = 0, n0 = 0;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];

    always #10 i_clk = ~i_clk;

    // Counted on the falling edge so a window never races the pulse
    always @(negedge i_clk) begin
        if (o_nv_store) n_nv++;
    end

    // Short counts so an hour is 12 cycles and a timer unit 1200
    plm_monitor #(.DC_CYC(20), .SEC_CYC(4), .HOUR_SEC(3), .WEAR_PCT(2))
        plm_monitor_inst (.i_clk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
        .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
        .o_rvalid, .i_rready, .i_contact_close, .i_running, .i_wear_tick,
        .i_power_off, .i_start_cmd, .i_output_shutoff_input, .i_trip,
        .i_motor_present, .i_cap_meas_pct, .i_fan_slow, .i_part_replaced,
        .o_life_alarm_out, .o_maint_alarm_out, .o_fan_fault_indication,
        .o_maintenance_indication, .o_term_out, .o_dc_inject, .o_nv_store);

    always @(posedge i_clk) begin
        if (o_rvalid && i_rready) `CHK({o_rresp, o_rdata}, rq.pop_front())
        if (o_bvalid && i_bready) `CHK(o_bresp, bq.pop_front())
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = 2'b00);
        bq.push_back(r);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        do @(posedge i_clk); while (!o_awready);
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        i_bready <= 1'b1;
        do @(posedge i_clk); while (!o_bvalid);
        i_bready <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = 2'b00);
        rq.push_back({r, d});
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do @(posedge i_clk); while (!o_arready);
        i_arvalid <= 1'b0;
        i_rready <= 1'b1;
        do @(posedge i_clk); while (!o_rvalid);
        i_rready <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic give_verdict;
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge i_clk);
        fails++;
        give_verdict();
    end

    initial begin
        void'($urandom(69117));
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        rd(plm_pkg::ADR_LIFE_STAT, 32'h0000_0000);
        rd(plm_pkg::ADR_LIMIT, 32'h0000_270f);
        rd(plm_pkg::ADR_MEAS_CTL, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000, 2'b10);
        wr(8'h20, 32'h0000_0000, 2'b10);
        wr(plm_pkg::ADR_LIMIT, 32'h0000_2710);
        rd(plm_pkg::ADR_LIMIT, 32'h0000_270f);
        // Clear first so the partial timer unit since reset is dropped
        wr(plm_pkg::ADR_HOURS, 32'h0000_0000);
        wr(plm_pkg::ADR_LIMIT, 32'h0000_0001);
        wr(plm_pkg::ADR_HOURS, 32'h0000_0005);
        rd(plm_pkg::ADR_HOURS, 32'h0000_0000);
        repeat (1150) @(posedge i_clk);
        `CHK(o_maint_alarm_out, 1'b0)
        repeat (100) @(posedge i_clk);
        `CHK(o_maint_alarm_out, 1'b1)
        `CHK(o_maintenance_indication, 1'b1)
        rd(plm_pkg::ADR_HOURS, 32'h0000_0001);
        // Ten whole hours of 12 cycles each
        n0 = n_nv;
        repeat (120) @(posedge i_clk);
        `CHK(n_nv - n0, 10)
        wr(plm_pkg::ADR_TERM_SEL, 32'h0000_005f);
        `CHK(o_term_out, 1'b1)
        wr(plm_pkg::ADR_TERM_SEL, 32'h0000_00c3);
        `CHK(o_term_out, 1'b0)
        wr(plm_pkg::ADR_LIMIT, 32'h0000_270f);
        `CHK(o_maint_alarm_out, 1'b0)
        i_contact_close <= 1'b1;
        repeat (9999) @(posedge i_clk);
        i_contact_close <= 1'b0;
        rd(plm_pkg::ADR_INRUSH, 32'h0000_0064);
        i_contact_close <= 1'b1;
        @(posedge i_clk);
        i_contact_close <= 1'b0;
        rd(plm_pkg::ADR_INRUSH, 32'h0000_0063);
        i_fan_slow <= 2'b10;
        repeat (5) @(posedge i_clk);
        `CHK(o_fan_fault_indication, 1'b1)
        `CHK(o_life_alarm_out, 1'b1)
        rd(plm_pkg::ADR_LIFE_STAT, 32'h0000_0004);
        pct = 7'($urandom_range(50, 85));
        i_cap_meas_pct <= pct;
        wr(plm_pkg::ADR_MEAS_CTL, 32'h0000_0001);
        i_power_off <= 1'b1;
        repeat (3) @(posedge i_clk);
        `CHK(o_dc_inject, 1'b1)
        rd(plm_pkg::ADR_MEAS_CTL, 32'h0000_0002);
        repeat (30) @(posedge i_clk);
        `CHK(o_dc_inject, 1'b0)
        i_power_off <= 1'b0;
        rd(plm_pkg::ADR_MEAS_CTL, 32'h0000_0003);
        rd(plm_pkg::ADR_MAIN_CAP, 32'(pct));
        rd(plm_pkg::ADR_LIFE_STAT, 32'h0000_0006);
        wr(plm_pkg::ADR_MEAS_CTL, 32'h0000_0009);
        rd(plm_pkg::ADR_MEAS_CTL, 32'h0000_0003);
        // Power cut every 12 cycles: 1210 powered cycles, no whole hour
        wr(plm_pkg::ADR_HOURS, 32'h0000_0000);
        n0 = n_nv;
        for (int h = 0; h < 110; h++) begin
            i_power_off <= 1'b1;
            @(posedge i_clk);
            i_power_off <= 1'b0;
            repeat (11) @(posedge i_clk);
        end
        `CHK(n_nv - n0, 0)
        rd(plm_pkg::ADR_HOURS, 32'h0000_0000);
        wr(plm_pkg::ADR_MEAS_CTL, 32'h0000_0001);
        i_power_off <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_start_cmd <= 1'b1;
        @(posedge i_clk);
        i_start_cmd <= 1'b0;
        rd(plm_pkg::ADR_MEAS_CTL, 32'h0000_0008);
        `CHK(o_dc_inject, 1'b0)
        i_power_off <= 1'b0;
        wr(plm_pkg::ADR_MEAS_CTL, 32'h0000_0001);
        i_power_off <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_power_off <= 1'b0;
        @(posedge i_clk);
        rd(plm_pkg::ADR_MEAS_CTL, 32'h0000_0001);
        i_trip <= 1'b1;
        i_power_off <= 1'b1;
        @(posedge i_clk);
        i_trip <= 1'b0;
        i_power_off <= 1'b0;
        rd(plm_pkg::ADR_MEAS_CTL, 32'h0000_0009);
        i_running <= 1'b1;
        for (int k = 0; k < 182; k++) begin
            i_wear_tick <= 1'b1;
            @(posedge i_clk);
            i_wear_tick <= 1'b0;
            @(posedge i_clk);
            if (k == 179) begin
                rd(plm_pkg::ADR_CTRL_CAP, 32'h0000_000a);
                rd(plm_pkg::ADR_LIFE_STAT, 32'h0000_0006);
            end
        end
        rd(plm_pkg::ADR_CTRL_CAP, 32'h0000_0009);
        rd(plm_pkg::ADR_LIFE_STAT, 32'h0000_0007);
        i_fan_slow <= 2'b00;
        i_part_replaced <= 4'hf;
        @(posedge i_clk);
        i_part_replaced <= 4'h0;
        repeat (5) @(posedge i_clk);
        rd(plm_pkg::ADR_LIFE_STAT, 32'h0000_0000);
        `CHK(o_life_alarm_out, 1'b0)
        give_verdict();
    end
endmodule
